// [verilog/mpgpio_top.sv]
`timescale 1ns/1ps
// Operation
// - enable clear: first pin is diode-one alert
// - enable set: pin outputs pulse, high-side off
// - third alert field: alert, I/O, pulse four
// - pulse four ignored unless selected
// - second alert field: alert, I/O, pulse three
// - function clear: pulse two out, linear driver off
// - function set: I/O pin, linear driver on
// - tach bit set: I/O, speed loop forced off
// - clock bit clear: clock input, else I/O
// - direction bits: 0 input, 1 output
// - drive type for outputs; alerts open drain
// - first pulse drive: 0 open drain, 1 push-pull
// - pin drive bits: 0 open drain, 1 push-pull
// - input register shows levels of pins 0..5; first pin not read
// - input change asserts alert unless masked
// - open drain: 1 releases, 0 drives low
// - push-pull drives output bit level directly
// - enable bits gate alert, inputs only
// - change flag sticky until status read
module mpgpio_top #(
  parameter int NPINS = mpgpio_pkg::NUM_PINS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire mpgpio_pkg::mpgpio_req_s busReq,
  output logic [7:0] busRdData,
  input wire logic diodeOneAlert,
  input wire logic diodeTwoAlert,
  input wire logic diodeThreeAlert,
  input wire logic firstPulseChannel,
  input wire logic secondPulseChannel,
  input wire logic thirdPulseChannel,
  input wire logic fourthPulseChannel,
  input wire logic secondSpeedLoopEnableReq,
  input wire logic gpioMaskN,
  input wire logic firstPinIn,
  output mpgpio_pkg::mpgpio_pad_s firstPinPad,
  input wire logic [NPINS-1:0] pinIn,
  output mpgpio_pkg::mpgpio_pad_s [NPINS-1:0] pinPad,
  output logic highSideDriverEnable,
  output logic linearDriverEnable,
  output logic linearDriverOutputHiZ,
  output logic secondSpeedLoopEnable,
  output logic secondTachometerInput,
  output logic speedControlClock,
  output logic gpioChangeAlertN,
  output logic gpioStatusAny
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] pinFunctionSelect;
  logic [NPINS-1:0] pinDirection;
  logic [6:0] pinDriveType;
  logic [NPINS-1:0] pinLevelOut;
  logic [NPINS-1:0] pinChangeAlertEnable;
  logic [NPINS-1:0] pinChangeFlag;
  logic [NPINS-1:0] pinLevel;
  logic [NPINS-1:0] pinChanged;
  logic [NPINS-1:0] isGpio;
  logic [NPINS-1:0] isGpioIn;
  logic [NPINS-1:0] isPulse;
  logic [NPINS-1:0] pulseLevel;
  logic [NPINS-1:0] next_pinChangeFlag;
  logic firstPulsePinEnable;
  logic [1:0] thirdAlertPinFunction;
  logic [1:0] secondAlertPinFunction;
  logic secondPulsePinFunction;
  logic secondTachPinFunction;
  logic clockPinFunction;
  logic firstPulseDriveType;
  logic [NPINS-1:0] pinDriveTypeBit;

  // 00 alert, 11 pulse, others plain I/O
  function automatic logic alertFieldIsGpio(input logic [1:0] fn);
    alertFieldIsGpio = (fn != mpgpio_pkg::ALERT_FN_DIODE) && (fn != mpgpio_pkg::ALERT_FN_PULSE);
  endfunction

  function automatic logic alertFieldIsPulse(input logic [1:0] fn);
    alertFieldIsPulse = (fn == mpgpio_pkg::ALERT_FN_PULSE);
  endfunction

  // pad from drive type: push-pull drives either level, open drain only low
  function automatic mpgpio_pkg::mpgpio_pad_s drivePad(input logic level, input logic pushPull);
    drivePad.out = pushPull ? level : 1'b0;
    drivePad.oeN = pushPull ? 1'b0 : level;
  endfunction

  assign firstPulsePinEnable = pinFunctionSelect[mpgpio_pkg::FIRST_PULSE_PIN_ENABLE_BIT];
  assign thirdAlertPinFunction = pinFunctionSelect[mpgpio_pkg::THIRD_ALERT_PIN_FUNCTION_LSB +: 2];
  assign secondAlertPinFunction = pinFunctionSelect[mpgpio_pkg::SECOND_ALERT_PIN_FUNCTION_LSB +: 2];
  assign secondPulsePinFunction = pinFunctionSelect[mpgpio_pkg::SECOND_PULSE_PIN_FUNCTION_BIT];
  assign secondTachPinFunction = pinFunctionSelect[mpgpio_pkg::SECOND_TACH_PIN_FUNCTION_BIT];
  assign clockPinFunction = pinFunctionSelect[mpgpio_pkg::CLOCK_PIN_FUNCTION_BIT];
  assign firstPulseDriveType = pinDriveType[mpgpio_pkg::FIRST_PULSE_DRIVE_TYPE_BIT];
  assign pinDriveTypeBit = pinDriveType[NPINS-1:0];

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinFunctionSelect <= mpgpio_pkg::RST_PIN_FUNCTION_SELECT;
    end else if (busReq.wrEn && busReq.addr == mpgpio_pkg::ADDR_PIN_FUNCTION_SELECT) begin
      pinFunctionSelect <= busReq.wrData;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinDirection <= mpgpio_pkg::RST_PIN_DIRECTION[NPINS-1:0];
    end else if (busReq.wrEn && busReq.addr == mpgpio_pkg::ADDR_PIN_DIRECTION) begin
      pinDirection <= busReq.wrData[NPINS-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinDriveType <= mpgpio_pkg::RST_PIN_DRIVE_TYPE[6:0];
    end else if (busReq.wrEn && busReq.addr == mpgpio_pkg::ADDR_PIN_DRIVE_TYPE) begin
      pinDriveType <= busReq.wrData[6:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinLevelOut <= mpgpio_pkg::RST_PIN_LEVEL_OUT[NPINS-1:0];
    end else if (busReq.wrEn && busReq.addr == mpgpio_pkg::ADDR_PIN_LEVEL_OUT) begin
      pinLevelOut <= busReq.wrData[NPINS-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinChangeAlertEnable <= mpgpio_pkg::RST_PIN_CHANGE_ALERT_ENABLE[NPINS-1:0];
    end else if (busReq.wrEn && busReq.addr == mpgpio_pkg::ADDR_PIN_CHANGE_ALERT_ENABLE) begin
      pinChangeAlertEnable <= busReq.wrData[NPINS-1:0];
    end
  end

  // ------------------------------------------------------------
  // pin function decode
  // ------------------------------------------------------------
  always_comb begin
    isGpio = '1;
    isPulse = '0;
    pulseLevel = '0;
    isGpio[mpgpio_pkg::PIN_CLOCK] = clockPinFunction;
    isGpio[mpgpio_pkg::PIN_SECOND_TACH] = secondTachPinFunction;
    isGpio[mpgpio_pkg::PIN_PULSE2] = secondPulsePinFunction;
    isPulse[mpgpio_pkg::PIN_PULSE2] = !secondPulsePinFunction;
    pulseLevel[mpgpio_pkg::PIN_PULSE2] = secondPulseChannel;
    isGpio[mpgpio_pkg::PIN_ALERT2] = alertFieldIsGpio(secondAlertPinFunction);
    isPulse[mpgpio_pkg::PIN_ALERT2] = alertFieldIsPulse(secondAlertPinFunction);
    pulseLevel[mpgpio_pkg::PIN_ALERT2] = thirdPulseChannel;
    isGpio[mpgpio_pkg::PIN_ALERT3] = alertFieldIsGpio(thirdAlertPinFunction);
    isPulse[mpgpio_pkg::PIN_ALERT3] = alertFieldIsPulse(thirdAlertPinFunction);
    pulseLevel[mpgpio_pkg::PIN_ALERT3] = fourthPulseChannel;
  end

  assign isGpioIn = isGpio & ~pinDirection;

  // ------------------------------------------------------------
  // pad drivers
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pad
      always_comb begin
        if (isGpio[gi] && pinDirection[gi]) begin
          pinPad[gi] = drivePad(pinLevelOut[gi], pinDriveTypeBit[gi]);
        end else if (isPulse[gi]) begin
          pinPad[gi] = drivePad(pulseLevel[gi], pinDriveTypeBit[gi]);
        end else if (gi == mpgpio_pkg::PIN_ALERT2 && !isGpio[gi]) begin
          pinPad[gi] = drivePad(diodeTwoAlert, 1'b0);
        end else if (gi == mpgpio_pkg::PIN_ALERT3 && !isGpio[gi]) begin
          pinPad[gi] = drivePad(diodeThreeAlert, 1'b0);
        end else begin
          // input or dedicated input function: released
          pinPad[gi] = drivePad(1'b1, 1'b0);
        end
      end
    end
  endgenerate

  // first shared pin: alert is active low and always open drain
  always_comb begin
    if (firstPulsePinEnable) begin
      firstPinPad = drivePad(firstPulseChannel, firstPulseDriveType);
    end else begin
      firstPinPad = drivePad(diodeOneAlert, 1'b0);
    end
  end

  assign highSideDriverEnable = !firstPulsePinEnable;
  assign linearDriverEnable = secondPulsePinFunction;
  assign linearDriverOutputHiZ = !secondPulsePinFunction;
  assign secondSpeedLoopEnable = secondSpeedLoopEnableReq && !secondTachPinFunction;
  assign secondTachometerInput = secondTachPinFunction ? 1'b0 : pinLevel[mpgpio_pkg::PIN_SECOND_TACH];
  assign speedControlClock = clockPinFunction ? 1'b0 : pinLevel[mpgpio_pkg::PIN_CLOCK];

  // ------------------------------------------------------------
  // input sampling and change status
  // ------------------------------------------------------------
  mpgpio_edge_detect #(
    .WIDTH(NPINS)
  ) u_edge (
    .sys_clk(sys_clk),
    .rst(rst),
    .padIn(pinIn),
    .level(pinLevel),
    .changed(pinChanged)
  );

  logic statusRead;
  assign statusRead = busReq.rdEn && busReq.addr == mpgpio_pkg::ADDR_PIN_CHANGE_STATUS;

  // a new change in the read cycle survives the clear
  always_comb begin
    next_pinChangeFlag = statusRead ? '0 : pinChangeFlag;
    next_pinChangeFlag = next_pinChangeFlag | (pinChanged & isGpioIn);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinChangeFlag <= mpgpio_pkg::RST_PIN_CHANGE_STATUS;
    end else begin
      pinChangeFlag <= next_pinChangeFlag;
    end
  end

  // alert stays asserted while gpioMaskN is high and an enabled flag of a GPIO input stands
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gpioChangeAlertN <= 1'b1;
    end else begin
      gpioChangeAlertN <= !(gpioMaskN && |(next_pinChangeFlag & pinChangeAlertEnable & isGpioIn));
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gpioStatusAny <= 1'b0;
    end else begin
      gpioStatusAny <= |next_pinChangeFlag;
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busRdData <= 8'h00;
    end else if (busReq.rdEn) begin
      case (busReq.addr)
        mpgpio_pkg::ADDR_PIN_FUNCTION_SELECT: busRdData <= pinFunctionSelect;
        mpgpio_pkg::ADDR_PIN_DIRECTION: busRdData <= {2'h0, pinDirection};
        mpgpio_pkg::ADDR_PIN_DRIVE_TYPE: busRdData <= {1'h0, pinDriveType};
        mpgpio_pkg::ADDR_PIN_LEVEL_IN: busRdData <= {2'h0, pinLevel};
        mpgpio_pkg::ADDR_PIN_LEVEL_OUT: busRdData <= {2'h0, pinLevelOut};
        mpgpio_pkg::ADDR_PIN_CHANGE_ALERT_ENABLE: busRdData <= {2'h0, pinChangeAlertEnable};
        mpgpio_pkg::ADDR_PIN_CHANGE_STATUS: busRdData <= {2'h0, pinChangeFlag};
        default: busRdData <= 8'h00;
      endcase
    end
  end
endmodule // mpgpio_top

// [verilog/mpgpio_pkg.sv]
package mpgpio_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_PIN_FUNCTION_SELECT = 8'hE0;
  localparam logic [7:0] ADDR_PIN_DIRECTION = 8'hE1;
  localparam logic [7:0] ADDR_PIN_DRIVE_TYPE = 8'hE2;
  localparam logic [7:0] ADDR_PIN_LEVEL_IN = 8'hE3;
  localparam logic [7:0] ADDR_PIN_LEVEL_OUT = 8'hE4;
  localparam logic [7:0] ADDR_PIN_CHANGE_ALERT_ENABLE = 8'hE5;
  localparam logic [7:0] ADDR_PIN_CHANGE_STATUS = 8'hE6;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_PIN_FUNCTION_SELECT = 8'h01;
  localparam logic [7:0] RST_PIN_DIRECTION = 8'h00;
  localparam logic [7:0] RST_PIN_DRIVE_TYPE = 8'h00;
  localparam logic [7:0] RST_PIN_LEVEL_OUT = 8'h00;
  localparam logic [7:0] RST_PIN_CHANGE_ALERT_ENABLE = 8'h00;
  localparam logic [5:0] RST_PIN_CHANGE_STATUS = 6'h00;

  // ------------------------------------------------------------
  // field positions in pin_function_select / pin_drive_type
  // ------------------------------------------------------------
  localparam int FIRST_PULSE_PIN_ENABLE_BIT = 7;
  localparam int THIRD_ALERT_PIN_FUNCTION_LSB = 5;
  localparam int SECOND_ALERT_PIN_FUNCTION_LSB = 3;
  localparam int SECOND_PULSE_PIN_FUNCTION_BIT = 2;
  localparam int SECOND_TACH_PIN_FUNCTION_BIT = 1;
  localparam int CLOCK_PIN_FUNCTION_BIT = 0;
  localparam int FIRST_PULSE_DRIVE_TYPE_BIT = 6;
  localparam int NUM_PINS = 6;

  // alert-pin function field codes
  localparam logic [1:0] ALERT_FN_DIODE = 2'h0;
  localparam logic [1:0] ALERT_FN_PULSE = 2'h3;

  // shared-pin indices (0 = clock pin ... 5 = sixth plain pin)
  localparam int PIN_CLOCK = 0;
  localparam int PIN_SECOND_TACH = 1;
  localparam int PIN_PULSE2 = 2;
  localparam int PIN_ALERT2 = 3;
  localparam int PIN_ALERT3 = 4;

  // ------------------------------------------------------------
  // bus carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } mpgpio_req_s;

  // pad carrier: open-drain style, oeN low while driving
  typedef struct packed {
    logic out;
    logic oeN;
  } mpgpio_pad_s;
endpackage

// [verilog/mpgpio_edge_detect.sv]
`timescale 1ns/1ps
// two-flop synchroniser followed by change detector for every pin
module mpgpio_edge_detect #(
  parameter int WIDTH = 6
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] padIn,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] changed
);
  logic [WIDTH-1:0] syncStage;
  logic [WIDTH-1:0] syncLevel;
  logic [WIDTH-1:0] prevLevel;
  // marks which pipeline stages hold real samples since reset
  logic [2:0] filled;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      syncStage <= '0;
      syncLevel <= '0;
    end else begin
      syncStage <= padIn;
      syncLevel <= syncStage;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prevLevel <= '0;
      filled <= 3'h0;
    end else begin
      prevLevel <= syncLevel;
      filled <= {filled[1:0], 1'b1};
    end
  end

  assign level = syncLevel;
  // one event per settled transition; reset zeros are not pin levels, so no false edge after reset
  assign changed = filled[2] ? (syncLevel ^ prevLevel) : '0;
endmodule // mpgpio_edge_detect

// [tb/mpgpio_chk.sv]
`timescale 1ns/1ps
module mpgpio_chk #(
  parameter int NPINS = 6
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire mpgpio_pkg::mpgpio_req_s busReq,
  input wire logic diodeOneAlert,
  input wire logic diodeTwoAlert,
  input wire logic diodeThreeAlert,
  input wire logic firstPulseChannel,
  input wire logic secondPulseChannel,
  input wire logic fourthPulseChannel,
  input wire logic [NPINS-1:0] pinIn,
  input wire logic secondTachometerInput,
  input wire logic speedControlClock,
  input wire logic secondSpeedLoopEnableReq,
  input wire mpgpio_pkg::mpgpio_pad_s firstPinPad,
  input wire mpgpio_pkg::mpgpio_pad_s [NPINS-1:0] pinPad,
  input wire logic highSideDriverEnable,
  input wire logic linearDriverEnable,
  input wire logic linearDriverOutputHiZ,
  input wire logic secondSpeedLoopEnable,
  input wire logic gpioChangeAlertN,
  input wire logic gpioStatusAny
);
  logic [7:0] fsel, dir, drv, lvl;
  // ------------------------------------------------------------
  // shadow of control registers, written at the same edge
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fsel <= 8'h01;
      dir <= 8'h00;
      drv <= 8'h00;
      lvl <= 8'h00;
    end else if (busReq.wrEn) begin
      case (busReq.addr)
        mpgpio_pkg::ADDR_PIN_FUNCTION_SELECT: fsel <= busReq.wrData;
        mpgpio_pkg::ADDR_PIN_DIRECTION: dir <= busReq.wrData;
        mpgpio_pkg::ADDR_PIN_DRIVE_TYPE: drv <= busReq.wrData;
        mpgpio_pkg::ADDR_PIN_LEVEL_OUT: lvl <= busReq.wrData;
        default: ;
      endcase
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_first_alert: assert property (!fsel[7] |-> !firstPinPad.out && firstPinPad.oeN == diodeOneAlert)
    else $error("first pin not on alert");
  a_first_pulse: assert property (fsel[7] |-> !highSideDriverEnable && (drv[6] ?
    !firstPinPad.oeN && firstPinPad.out == firstPulseChannel : !firstPinPad.out && firstPinPad.oeN == firstPulseChannel))
    else $error("first pin pulse wrong");
  a_third_alert: assert property (fsel[6:5] == 2'h0 |-> !pinPad[4].out && pinPad[4].oeN == diodeThreeAlert)
    else $error("third alert pin wrong");
  a_fourth_pulse: assert property (fsel[6:5] == 2'h3 && drv[4] |-> !pinPad[4].oeN && pinPad[4].out == fourthPulseChannel)
    else $error("fourth pulse pin wrong");
  a_second_alert: assert property (fsel[4:3] == 2'h0 |-> !pinPad[3].out && pinPad[3].oeN == diodeTwoAlert)
    else $error("second alert pin wrong");
  a_second_pulse: assert property (!fsel[2] && drv[2] |-> !pinPad[2].oeN && pinPad[2].out == secondPulseChannel)
    else $error("second pulse pin wrong");
  a_clock_route: assert property (!$past(rst) && !$past(rst, 2) |-> speedControlClock == (!fsel[0] && $past(pinIn[0], 2)))
    else $error("clock input routing wrong");
  a_tach_route: assert property (!$past(rst) && !$past(rst, 2) |-> secondTachometerInput == (!fsel[1] && $past(pinIn[1], 2)))
    else $error("tach input routing wrong");
  a_linear_drive: assert property (linearDriverEnable == fsel[2] && linearDriverOutputHiZ == !fsel[2])
    else $error("linear driver state wrong");
  a_speed_loop: assert property (secondSpeedLoopEnable == (secondSpeedLoopEnableReq && !fsel[1]))
    else $error("speed loop enable wrong");
  a_gpio_input: assert property (!dir[5] |-> pinPad[5].oeN)
    else $error("input pin driven");
  a_open_drain: assert property (dir[5] && !drv[5] |-> !pinPad[5].out && pinPad[5].oeN == lvl[5])
    else $error("open drain drive wrong");
  a_push_pull: assert property (dir[5] && drv[5] |-> !pinPad[5].oeN && pinPad[5].out == lvl[5])
    else $error("push pull drive wrong");
  a_alert_cause: assert property ($fell(gpioChangeAlertN) |-> gpioStatusAny)
    else $error("alert without flag");
  a_flag_sticky: assert property (gpioStatusAny && !(busReq.rdEn && busReq.addr == 8'hE6) |=> gpioStatusAny)
    else $error("change flag lost");
endmodule // mpgpio_chk

bind mpgpio_top mpgpio_chk #(.NPINS(NPINS)) chk_u (.sys_clk(sys_clk), .rst(rst), .busReq(busReq),
  .diodeOneAlert(diodeOneAlert), .diodeThreeAlert(diodeThreeAlert), .firstPulseChannel(firstPulseChannel),
  .diodeTwoAlert(diodeTwoAlert), .secondPulseChannel(secondPulseChannel), .pinIn(pinIn),
  .secondTachometerInput(secondTachometerInput), .speedControlClock(speedControlClock),
  .fourthPulseChannel(fourthPulseChannel), .secondSpeedLoopEnableReq(secondSpeedLoopEnableReq),
  .firstPinPad(firstPinPad), .pinPad(pinPad), .highSideDriverEnable(highSideDriverEnable),
  .linearDriverEnable(linearDriverEnable), .linearDriverOutputHiZ(linearDriverOutputHiZ),
  .secondSpeedLoopEnable(secondSpeedLoopEnable), .gpioChangeAlertN(gpioChangeAlertN), .gpioStatusAny(gpioStatusAny));

// [tb/mpgpio_pins.sv]
`timescale 1ns/1ps
module mpgpio_pins (
  input wire mpgpio_pkg::mpgpio_pad_s firstPinPad,
  input wire mpgpio_pkg::mpgpio_pad_s [5:0] pinPad,
  input wire logic [5:0] extEn,
  input wire logic [5:0] extLvl,
  output logic firstPinIn,
  output logic [5:0] pinIn
);
  // released pins go to the pull-up unless a far-side load drives them
  assign firstPinIn = firstPinPad.oeN ? 1'b1 : firstPinPad.out;
  for (genvar i = 0; i < 6; i++) begin : g_pin
    assign pinIn[i] = !pinPad[i].oeN ? pinPad[i].out : (extEn[i] ? extLvl[i] : 1'b1);
  end
endmodule // mpgpio_pins

// [tb/multiplexed_pin_gpio_test.sv]
`timescale 1ns/1ps
module multiplexed_pin_gpio_test;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  mpgpio_pkg::mpgpio_req_s busReq = '0;
  logic [7:0] busRdData, noise = 8'hFF, got;
  logic gpioMaskN = 1'b1, firstPinIn, gpioChangeAlertN, gpioStatusAny;
  logic [5:0] extEn = 6'h00, extLvl = 6'h00, pinIn;
  mpgpio_pkg::mpgpio_pad_s firstPinPad;
  mpgpio_pkg::mpgpio_pad_s [5:0] pinPad;
  int badCount = 0, checks = 0, cyc = 0, v, p;
  int mdl [7] = '{1, 0, 0, 0, 0, 0, 0};
  int msk [7] = '{255, 63, 127, 0, 63, 63, 0};

  mpgpio_top dut_u (.sys_clk(sys_clk), .rst(rst), .busReq(busReq), .busRdData(busRdData),
    .diodeOneAlert(noise[0]), .diodeTwoAlert(noise[1]), .diodeThreeAlert(noise[2]),
    .firstPulseChannel(noise[3]), .secondPulseChannel(noise[4]), .thirdPulseChannel(noise[5]),
    .fourthPulseChannel(noise[6]), .secondSpeedLoopEnableReq(noise[7]), .gpioMaskN(gpioMaskN),
    .firstPinIn(firstPinIn), .firstPinPad(firstPinPad), .pinIn(pinIn), .pinPad(pinPad),
    .highSideDriverEnable(), .linearDriverEnable(), .linearDriverOutputHiZ(), .secondSpeedLoopEnable(),
    .secondTachometerInput(), .speedControlClock(), .gpioChangeAlertN(gpioChangeAlertN),
    .gpioStatusAny(gpioStatusAny));
  mpgpio_pins pins_u (.firstPinPad(firstPinPad), .pinPad(pinPad), .extEn(extEn), .extLvl(extLvl),
    .firstPinIn(firstPinIn), .pinIn(pinIn));

  initial forever #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) noise <= #1 8'($urandom);
  // ------------------------------------------------------------
  // hang guard, well above the few hundred cycles the tests need
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      badCount++;
      finalReport();
    end
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    checks++;
    if (seen !== exp) begin
      badCount++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1;
    busReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
    @(posedge sys_clk) #1;
    busReq.wrEn = 1'b0;
    if (a >= 8'hE0 && a <= 8'hE6) mdl[a - 8'hE0] = d & msk[a - 8'hE0];
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] seen);
    @(posedge sys_clk) #1;
    busReq.rdEn = 1'b1;
    busReq.addr = a;
    @(posedge sys_clk) #1;
    busReq.rdEn = 1'b0;
    seen = busRdData;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] seen;
    rd(a, seen);
    check($sformatf("register %h", a), exp, seen);
  endtask

  task automatic finalReport();
    $display("comparisons %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    v = $urandom(9901);
    repeat (20) @(posedge sys_clk);
    #1 rst = 1'b0;
    // ------------------------------------------------------------
    // reset values, unmapped read
    // ------------------------------------------------------------
    for (int i = 0; i < 7; i++) if (i != 3) rdc(8'hE0 + 8'(i), 8'(mdl[i]));
    // pins 2..4 follow random alert and pulse levels; released pins sit at the pull-up
    rd(8'hE3, got);
    check("idle pin levels", 8'h23, got & 8'h23);
    rdc(8'h10, 8'h00);
    $display("test reset values done");
    // ------------------------------------------------------------
    // every pin-function code, random settings, read back
    // ------------------------------------------------------------
    for (int k = 0; k < 8; k++) begin
      v = $urandom;
      wr(8'hE0, {v[7], 2'(k), 2'(k + 1), k[0], k[1], k[2]});
      for (int i = 1; i < 7; i++) wr(8'hE0 + 8'(i), 8'($urandom));
      for (int i = 0; i < 6; i++) if (i != 3) rdc(8'hE0 + 8'(i), 8'(mdl[i]));
      repeat (4) @(posedge sys_clk);
    end
    $display("test pin functions done");
    // ------------------------------------------------------------
    // input register against driven and loaded pins
    // ------------------------------------------------------------
    wr(8'hE0, 8'h2F);
    wr(8'hE1, 8'h3F);
    wr(8'hE5, 8'h00);
    for (int k = 0; k < 8; k++) begin
      v = $urandom;
      extEn = 6'h3F;
      extLvl = 6'(v >> 8);
      wr(8'hE2, k[0] ? 8'h3F : 8'h00);
      wr(8'hE4, 8'(v) & 8'h3F);
      if (k[0]) extEn = 6'h00;
      repeat (3) @(posedge sys_clk);
      rdc(8'hE3, k[0] ? 8'(v & 63) : 8'(v & (v >> 8) & 63));
    end
    $display("test input register done");
    // ------------------------------------------------------------
    // change flags and alert: enabled, masked, disabled
    // ------------------------------------------------------------
    wr(8'hE1, 8'h00);
    extEn = 6'h3F;
    for (int k = 0; k < 6; k++) begin
      p = $urandom_range(5);
      gpioMaskN = (k % 3 != 1);
      wr(8'hE5, (k % 3 == 2) ? 8'h00 : 8'h3F);
      repeat (4) @(posedge sys_clk);
      rd(8'hE6, got);
      @(posedge sys_clk) #1;
      extLvl[p] = ~extLvl[p];
      repeat (5) @(posedge sys_clk) #1;
      check("alert", 8'(k % 3 != 0), 8'(gpioChangeAlertN));
      rdc(8'hE6, 8'h01 << p);
      rdc(8'hE6, 8'h00);
      check("alert cleared", 8'h01, 8'(gpioChangeAlertN));
    end
    $display("test change alert done");
    finalReport();
  end
endmodule // multiplexed_pin_gpio_test
